// [hw/rx_mode_regs.sv]
// Module: receive-mode and self-test control registers behind APB
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
module rx_mode_regs
  import rx_mode_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Strap pins, sampled after reset release
  input  wire logic        mode_strap_fast,
  input  wire logic        mode_strap_coax,
  input  wire logic        mode_strap_repeater,
  // Receiver datapath and configuration
  input  wire logic        auto_clock_enable,
  input  wire logic        line_end_pulse,
  input  wire logic [7:0]  line_checksum_rx,
  input  wire logic [7:0]  line_checksum_calc,
  input  wire logic [3:0]  aux_audio_code,
  input  wire logic [2:0]  self_test_pin_cfg,
  output logic             line_checksum_enable,
  output logic             link_security_state,
  output logic [1:0]       backchan_rate,
  output logic             backchan_settling,
  output logic             coax_select,
  output logic             auto_audio_mode,
  output logic [3:0]       audio_mode,
  output logic             osc_clock_valid,
  output logic [1:0]       osc_receive_clock_rate,
  output logic [2:0]       self_test_cfg,
  output logic             self_test_running,
  output logic             internal_pixel_clock,
  // Forwarding to remote serializer
  output logic             far_write_valid,
  output logic [7:0]       far_write_addr,
  output logic [7:0]       far_write_data,
  input  wire logic        far_write_ready,
  // Interrupt
  output logic             irq
);

  //////////////////////////////////////////////////////////////////////////////
  // Reset and strap synchronisers
  logic       rst_meta_q;
  logic       rst_sync_q;
  logic [2:0] strap_meta_q;
  logic [2:0] strap_sync_q;
  logic       strap_done_q;
  logic [1:0] strap_wait_q;
  logic       rst_n;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_n = rst_sync_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strap_meta_q <= 3'h0;
      strap_sync_q <= 3'h0;
    end else begin
      strap_meta_q <= {mode_strap_repeater, mode_strap_coax, mode_strap_fast};
      strap_sync_q <= strap_meta_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB decode; zero wait states
  function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
    hit = (a == {2'h0, idx, 2'h0});
  endfunction

  logic wr_en;
  logic wr_rx;
  logic wr_st;
  logic wr_ien;
  logic wr_clr;
  logic known;

  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  assign wr_rx   = wr_en && hit(paddr, RX_MODE_IDX);
  assign wr_st   = wr_en && hit(paddr, SELF_TEST_IDX);
  assign wr_ien  = wr_en && hit(paddr, IRQ_ENABLE_IDX);
  assign wr_clr  = wr_en && hit(paddr, IRQ_CLEAR_IDX);
  assign known   = hit(paddr, RX_MODE_IDX) || hit(paddr, SELF_TEST_IDX) ||
                   hit(paddr, IRQ_STATUS_IDX) || hit(paddr, IRQ_ENABLE_IDX) ||
                   hit(paddr, IRQ_CLEAR_IDX);
  assign pslverr = psel && penable && !known;

  //////////////////////////////////////////////////////////////////////////////
  // receiver_mode_state
  logic [7:0] rx_mode_q;

  // Straps need two edges to cross the synchroniser; load only once they stand in the
  // second flop, otherwise the bank would latch the flops' reset zeros instead
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_mode_q    <= RX_MODE_RESET;
      strap_done_q <= 1'b0;
      strap_wait_q <= 2'h0;
    end else if (strap_wait_q != 2'h2) begin
      strap_wait_q <= strap_wait_q + 2'h1;
    end else if (!strap_done_q) begin
      strap_done_q            <= 1'b1;
      rx_mode_q[FAST_BC_BIT]  <= strap_sync_q[0];
      rx_mode_q[COAX_BIT]     <= strap_sync_q[1];
      rx_mode_q[REPEATER_BIT] <= strap_sync_q[2];
    end else if (wr_rx) begin
      rx_mode_q <= (pwdata[7:0] & RX_MODE_WR_MASK) |
                   (rx_mode_q & ~RX_MODE_WR_MASK);
    end
  end

  assign line_checksum_enable = rx_mode_q[CSUM_EN_BIT];
  assign coax_select          = rx_mode_q[COAX_BIT];
  assign auto_audio_mode      = rx_mode_q[AUTO_AUDIO_BIT];

  // Back channel rate: fast bit overrides the select bit
  always_comb begin
    if (rx_mode_q[FAST_BC_BIT]) begin
      backchan_rate = BC_FAST_20M;
    end else if (rx_mode_q[RATE_SEL_BIT]) begin
      backchan_rate = BC_DIV2;
    end else begin
      backchan_rate = BC_DIV4;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Rate change settling window; errors in it are expected, not faults
  logic [1:0] rate_prev_q;
  logic [7:0] settle_q;
  logic       rate_changed;

  assign rate_changed = strap_done_q && (rate_prev_q != backchan_rate);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rate_prev_q <= BC_DIV4;
      settle_q    <= 8'h00;
    end else begin
      rate_prev_q <= backchan_rate;
      if (rate_changed) begin
        settle_q <= 8'(SETTLE_CYC);
      end else if (settle_q != 8'h00) begin
        settle_q <= settle_q - 8'h01;
      end
    end
  end
  assign backchan_settling = (settle_q != 8'h00);

  //////////////////////////////////////////////////////////////////////////////
  // Auto audio mode from aux codes
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      audio_mode <= 4'h0;
    end else if (rx_mode_q[AUTO_AUDIO_BIT]) begin
      audio_mode <= aux_audio_code;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Line checksum check; one compare per line end
  logic csum_fail;
  assign csum_fail = line_end_pulse && rx_mode_q[CSUM_EN_BIT] &&
                     (line_checksum_rx != line_checksum_calc);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link_security_state <= 1'b0;
    end else if (csum_fail) begin
      link_security_state <= 1'b1;
    end else if (wr_clr && pwdata[IRQ_CSUM_BIT]) begin
      link_security_state <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // self_test_control
  logic [7:0] self_test_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      self_test_q <= SELF_TEST_RESET;
    end else if (wr_st) begin
      self_test_q <= pwdata[7:0];
    end
  end

  assign self_test_running    = self_test_q[TEST_EN_BIT];
  assign self_test_cfg        = self_test_q[PIN_CFG_BIT] ? self_test_pin_cfg
                                                         : self_test_q[2:0];
  assign internal_pixel_clock = (self_test_q[CLK_SRC_LSB +: 2] != 2'h0);

  // Reserved code 11 leaves the oscillator clock marked invalid
  assign osc_receive_clock_rate = self_test_q[OSC_RATE_LSB +: 2];
  assign osc_clock_valid = auto_clock_enable &&
                           (osc_receive_clock_rate != 2'h3);

  //////////////////////////////////////////////////////////////////////////////
  // Forward clock source to serializer when self-test turns on
  logic st_en_prev_q;
  logic fwd_start;
  logic fwd_done;

  assign fwd_start = self_test_q[TEST_EN_BIT] && !st_en_prev_q;
  assign fwd_done  = far_write_valid && far_write_ready;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_en_prev_q    <= 1'b0;
      far_write_valid <= 1'b0;
      far_write_addr  <= 8'h00;
      far_write_data  <= 8'h00;
    end else begin
      st_en_prev_q <= self_test_q[TEST_EN_BIT];
      if (fwd_start) begin
        far_write_valid <= 1'b1;
        far_write_addr  <= FAR_MUX_IDX;
        far_write_data  <= {6'h00, self_test_q[CLK_SRC_LSB +: 2]};
      end else if (fwd_done) begin
        far_write_valid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupts: set wins over clear
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_en_q;
  logic [IRQ_W-1:0] irq_set;

  assign irq_set = {fwd_done, rate_changed, csum_fail};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= '0;
      irq_en_q   <= '0;
    end else begin
      irq_stat_q <= irq_set |
                    (irq_stat_q & ~(wr_clr ? pwdata[IRQ_W-1:0] : {IRQ_W{1'b0}}));
      if (wr_ien) begin
        irq_en_q <= pwdata[IRQ_W-1:0];
      end
    end
  end
  assign irq = |(irq_stat_q & irq_en_q);

  //////////////////////////////////////////////////////////////////////////////
  // Read mux
  always_comb begin
    prdata = 32'h0000_0000;
    if (hit(paddr, RX_MODE_IDX)) begin
      prdata[7:0] = rx_mode_q;
    end else if (hit(paddr, SELF_TEST_IDX)) begin
      prdata[7:0] = self_test_q;
    end else if (hit(paddr, IRQ_STATUS_IDX)) begin
      prdata[IRQ_W-1:0] = irq_stat_q;
    end else if (hit(paddr, IRQ_ENABLE_IDX)) begin
      prdata[IRQ_W-1:0] = irq_en_q;
    end
  end

endmodule // rx_mode_regs

`default_nettype wire

// [include/rx_mode_pkg.sv]
// Package: register map, field positions, reset values and encodings of the receive-mode bank
package rx_mode_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0]  RX_MODE_IDX      = 8'h23;
  localparam logic [7:0]  SELF_TEST_IDX    = 8'h24;
  localparam logic [7:0]  IRQ_STATUS_IDX   = 8'h30;
  localparam logic [7:0]  IRQ_ENABLE_IDX   = 8'h31;
  localparam logic [7:0]  IRQ_CLEAR_IDX    = 8'h33;
  localparam logic [7:0]  FAR_CMD_IDX      = 8'h35;
  localparam logic [7:0]  FAR_MUX_IDX      = 8'h14;

  // receiver_mode_state fields
  localparam int          CSUM_EN_BIT      = 7;
  localparam int          RATE_SEL_BIT     = 6;
  localparam int          AUTO_AUDIO_BIT   = 5;
  localparam int          FAST_BC_BIT      = 4;
  localparam int          COAX_BIT         = 3;
  localparam int          REPEATER_BIT     = 2;
  localparam logic [7:0]  RX_MODE_WR_MASK  = 8'hFB;
  localparam logic [7:0]  RX_MODE_RESET    = 8'h20;

  // self_test_control fields
  localparam int          OSC_RATE_LSB     = 4;
  localparam int          PIN_CFG_BIT      = 3;
  localparam int          CLK_SRC_LSB      = 1;
  localparam int          TEST_EN_BIT      = 0;
  localparam logic [7:0]  SELF_TEST_RESET  = 8'h08;

  // Interrupt status bits
  localparam int          IRQ_CSUM_BIT     = 0;
  localparam int          IRQ_RATE_BIT     = 1;
  localparam int          IRQ_FWD_BIT      = 2;
  localparam int          IRQ_W            = 3;

  // Back channel rate codes
  localparam logic [1:0]  BC_DIV4          = 2'h0;
  localparam logic [1:0]  BC_DIV2          = 2'h1;
  localparam logic [1:0]  BC_FAST_20M      = 2'h2;

  // Oscillator receive clock codes
  localparam logic [1:0]  OSC_50M          = 2'h0;
  localparam logic [1:0]  OSC_25M          = 2'h1;
  localparam logic [1:0]  OSC_10M          = 2'h2;

  // Rate change settling window, in ns and in 100 ns cycles
  localparam int          CLOCK_NS         = 100;
  localparam int          SETTLE_NS        = 2000;
  localparam int          SETTLE_CYC       = SETTLE_NS / CLOCK_NS;

endpackage

// [verif/far_ser_model.sv]
// Partner: remote serializer taking forwarded register writes
`timescale 1ns/1ps
`default_nettype none
module far_ser_model (
  // Clock and reset
  input wire logic       clock,
  input wire logic       nrst,
  // Forwarded write channel
  input wire logic       valid,
  input wire logic [7:0] addr,
  input wire logic [7:0] data,
  input wire logic [3:0] delay,
  output logic           ready
);
  // Auto-ack is taken as already on, so rate changes never stall it
  logic [7:0] mux_q;
  logic [7:0] addr_q;
  int         wait_q;
  int         hits;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ready <= 1'h0;
      wait_q <= 0;
      hits <= 0;
      mux_q <= 8'h00;
      addr_q <= 8'h00;
    end else if (valid && ready) begin
      mux_q <= data;
      addr_q <= addr;
      hits <= hits + 1;
      ready <= 1'h0;
      wait_q <= 0;
    end else if (valid) begin
      ready <= (wait_q >= delay);
      wait_q <= wait_q + 1;
    end else begin
      ready <= 1'h0;
    end
  end
endmodule // far_ser_model
`default_nettype wire

// [verif/rx_mode_props.sv]
// Checker: port-level properties of the receive-mode register bank
`timescale 1ns/1ps
`default_nettype none
module rx_mode_props
  import rx_mode_pkg::*;
(
  // Bus and inputs
  input wire logic        clock, nrst, psel, penable, pwrite, auto_clock_enable,
  input wire logic        line_end_pulse, far_write_ready,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [7:0]  line_checksum_rx, line_checksum_calc, far_write_addr,
  // Observed outputs
  input wire logic        line_checksum_enable, link_security_state, coax_select,
  input wire logic        osc_clock_valid, self_test_running, internal_pixel_clock,
  input wire logic        far_write_valid,
  input wire logic [1:0]  backchan_rate, osc_receive_clock_rate,
  input wire logic [2:0]  self_test_cfg
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  logic wr_rx, wr_st;
  assign wr_rx = psel && penable && pwrite && paddr == {2'h0, RX_MODE_IDX, 2'h0};
  assign wr_st = psel && penable && pwrite && paddr == {2'h0, SELF_TEST_IDX, 2'h0};
  //////////////////////////////////////////////////////////////////////////////
  sequence start_s; wr_st && pwdata[TEST_EN_BIT] && !self_test_running; endsequence
  sequence fwd_s; far_write_valid && far_write_addr == FAR_MUX_IDX; endsequence
  chk_csum_enable: assert property (wr_rx |=> line_checksum_enable == $past(pwdata[7]))
    else $error("checksum enable mismatch");
  chk_csum_flag: assert property (line_end_pulse && line_checksum_enable &&
    line_checksum_rx != line_checksum_calc |=> link_security_state) else $error("flag missing");
  chk_rate_div: assert property (wr_rx && !pwdata[4] |=>
    backchan_rate == {1'b0, $past(pwdata[6])}) else $error("rate select wrong");
  chk_rate_fast: assert property (wr_rx && pwdata[4] |=> backchan_rate == BC_FAST_20M)
    else $error("fast rate wrong");
  chk_cable_kind: assert property (wr_rx |=> coax_select == $past(pwdata[3]))
    else $error("cable select wrong");
  chk_osc_valid: assert property (osc_clock_valid ==
    (auto_clock_enable && osc_receive_clock_rate != 2'h3)) else $error("osc valid wrong");
  chk_cfg_source: assert property (wr_st && !pwdata[3] |=>
    self_test_cfg == $past(pwdata[2:0])) else $error("test config wrong");
  chk_pixel_src: assert property (wr_st |=>
    internal_pixel_clock == ($past(pwdata[2:1]) != 2'h0)) else $error("pixel clock wrong");
  chk_fwd_start: assert property (start_s |-> ##[1:3] fwd_s)
    else $error("forward write missing");
  chk_fwd_hold: assert property (far_write_valid && !far_write_ready |=>
    far_write_valid && $stable(far_write_addr)) else $error("forward write dropped");
  chk_test_run: assert property (wr_st |=> self_test_running == $past(pwdata[0]))
    else $error("test run state wrong");
endmodule // rx_mode_props

bind rx_mode_regs rx_mode_props chk (.*);
`default_nettype wire

// [verif/tb_receiver_mode_bist_control.sv]
// Testbench: receive-mode and self-test register bank against a bench model
`timescale 1ns/1ps
`default_nettype none
module tb_receiver_mode_bist_control;
  import rx_mode_pkg::*;
  logic clock = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, line_end_pulse = 1'h0, auto_clock_enable = 1'h0;
  logic mode_strap_fast = 1'h1, mode_strap_coax = 1'h0, mode_strap_repeater = 1'h1;
  logic [7:0] line_checksum_rx = 8'h00, line_checksum_calc = 8'h00, w, st;
  logic [3:0] aux_audio_code = 4'hA, far_delay = 4'h3, audio_mode;
  logic [2:0] self_test_pin_cfg = 3'h5, self_test_cfg;
  logic [1:0] backchan_rate, osc_receive_clock_rate;
  logic line_checksum_enable, link_security_state, backchan_settling, coax_select;
  logic auto_audio_mode, osc_clock_valid, self_test_running, internal_pixel_clock;
  logic far_write_valid, far_write_ready, irq;
  logic [7:0] far_write_addr, far_write_data;
  int fails = 0, compares = 0, rx_m, n, seed = 32'h7865;

  rx_mode_regs uut (.*);
  far_ser_model far (.clock(clock), .nrst(nrst), .valid(far_write_valid),
    .addr(far_write_addr), .data(far_write_data), .delay(far_delay), .ready(far_write_ready));

  always #50 clock = ~clock;
  //////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (fails == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; the slave is not trusted to answer at once
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    int k;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'h1 && k < 50);
    if (k >= 50) begin
      fails++;
      summarize();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clock);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clock);
    nrst <= 1'h1;
    repeat (5) @(posedge clock);
    rx_m = 32'h34;
    apb(1'h0, RX_MODE_IDX, 32'h0);
    chk(rd, rx_m);
    chk(auto_audio_mode, 1'h1);
    apb(1'h0, SELF_TEST_IDX, 32'h0);
    chk(rd, 32'h08);
    apb(1'h1, 8'h2F, 32'hFF);
    chk(er, 1'h1);
    repeat (8) begin
      w = $random(seed);
      apb(1'h1, RX_MODE_IDX, {24'h0, w});
      rx_m = (w & 8'hFB) | 8'h04;
      apb(1'h0, RX_MODE_IDX, 32'h0);
      chk(rd, rx_m);
      chk(backchan_rate, rx_m[4] ? 2 : rx_m[6]);
      chk(coax_select, rx_m[3]);
      chk(line_checksum_enable, rx_m[7]);
      if (rx_m[5]) chk(audio_mode, aux_audio_code);
    end
    auto_clock_enable <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      w = $random(seed);
      st = {w[7:6], i[1:0], i[0], w[2:1], 1'h0};
      apb(1'h1, SELF_TEST_IDX, {24'h0, st});
      apb(1'h0, SELF_TEST_IDX, 32'h0);
      chk(rd, st);
      chk(osc_clock_valid, i != 3);
      chk(self_test_cfg, st[3] ? self_test_pin_cfg : st[2:0]);
      chk(internal_pixel_clock, st[2:1] != 2'h0);
    end
    apb(1'h1, IRQ_ENABLE_IDX, 32'h1);
    apb(1'h1, IRQ_CLEAR_IDX, 32'h7);
    apb(1'h1, RX_MODE_IDX, 32'h80);
    line_checksum_rx <= 8'h5A;
    line_checksum_calc <= 8'hA5;
    line_end_pulse <= 1'h1;
    @(posedge clock);
    line_end_pulse <= 1'h0;
    repeat (2) @(posedge clock);
    chk(link_security_state, 1'h1);
    chk(irq, 1'h1);
    apb(1'h1, IRQ_ENABLE_IDX, 32'h0);
    chk(irq, 1'h0);
    apb(1'h1, IRQ_CLEAR_IDX, 32'h1);
    chk(link_security_state, 1'h0);
    far_delay <= 4'($random(seed) & 7);
    apb(1'h1, SELF_TEST_IDX, 32'h05);
    chk(self_test_running, 1'h1);
    n = 0;
    while (far.hits == 0 && n < 40) begin
      @(posedge clock);
      n++;
    end
    if (n >= 40) begin
      fails++;
      summarize();
    end
    chk(far.addr_q, FAR_MUX_IDX);
    chk(far.mux_q, 8'h02);
    apb(1'h1, SELF_TEST_IDX, 32'h04);
    chk(self_test_running, 1'h0);
    summarize();
  end
endmodule // tb_receiver_mode_bist_control
`default_nettype wire
